// ==== i2c_slave_address_match.sv ====
// two-wire bus slave address recognition, 7-bit and 10-bit, with clock stretching
// assumes software drives the control ports on CLOCK; the bus pins are open drain
`timescale 1ns/100ps
`default_nettype none

module i2c_slave_address_match
  import i2c_addr_pkg::*;
(
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // bus clock as a clock, and the bus wires
  input wire logic SCL_CLK,
  input wire logic SCL_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // configuration
  input wire logic [3:0] SLAVE_MODE_SELECT,
  input wire logic ADDRESS_HOLD_ENABLE,
  input wire logic DATA_HOLD_ENABLE,
  // address register access
  input wire logic ADDRESS_WRITE,
  input wire logic [7:0] ADDRESS_WRITE_DATA,
  output logic [7:0] SLAVE_ADDRESS_REG,
  // software acknowledge
  input wire logic ACK_GO,
  input wire logic ACK_DATA,
  // flag clears
  input wire logic BUFFER_READ,
  input wire logic IRQ_CLEAR,
  input wire logic OVERFLOW_CLEAR,
  // status
  output logic [7:0] RECEIVE_BUFFER_REG,
  output logic BUFFER_FULL_FLAG,
  output logic RECEIVE_OVERFLOW_FLAG,
  output logic SERIAL_PORT_IRQ_FLAG,
  output logic ADDRESS_UPDATE_NEEDED,
  output logic ACK_TIME_FLAG,
  output logic ADDRESSED,
  output logic READ_REQUEST
);

  // ----------------------------------------------------------------
  // bus clock domain and crossing
  // ----------------------------------------------------------------
  logic link_toggle;
  logic link_bit;
  lines_type raw_lines;
  lines_type lines;

  scl_edge_sampler u_link (
    .scl_clk(SCL_CLK),
    .rst(RESET),
    .sda(SDA_IN),
    .toggle(link_toggle),
    .bit_value(link_bit)
  );

  assign raw_lines = {SCL_IN, SDA_IN, link_toggle, link_bit};

  bit_sync #(
    .WIDTH($bits(lines_type)),
    .RESET_VALUE(LINES_RESET)
  ) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .d(raw_lines),
    .q(lines)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  state_type state_q;
  state_type state_d;
  logic scl_prev_q;
  logic sda_prev_q;
  logic toggle_prev_q;
  logic rise_evt_q;
  logic [3:0] bit_cnt_q;
  logic [3:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic ack_phase_q;
  logic ack_phase_d;
  logic [7:0] addr_q;
  logic [7:0] buffer_q;
  logic full_q;
  logic ov_q;
  logic irq_q;
  logic upd_q;
  logic upd_pending_q;
  logic upd_pending_d;
  logic hold_upd_q;
  logic hold_upd_d;
  logic hold_ack_q;
  logic hold_ack_d;
  logic ack_time_q;
  logic ack_ok_q;
  logic full_match10_q;
  logic full_match10_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic scl_oe_q;
  logic drive_level_q;
  logic addressed_q;
  logic read_q;

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  wire scl_high = scl_prev_q & lines.scl;
  wire scl_fall = scl_prev_q & ~lines.scl;
  wire start_det = scl_high & sda_prev_q & ~lines.sda;
  wire stop_det = scl_high & ~sda_prev_q & lines.sda;
  wire rise_now = lines.rise_toggle ^ toggle_prev_q;
  wire byte_done = scl_fall & ~ack_phase_q & (bit_cnt_q == ACK_BIT_COUNT);
  wire ack_end = scl_fall & ack_phase_q & (bit_cnt_q == ACK_END_COUNT);

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire mode_valid = (SLAVE_MODE_SELECT == MODE_7BIT) |
                    (SLAVE_MODE_SELECT == MODE_10BIT) |
                    (SLAVE_MODE_SELECT == MODE_7BIT_START_STOP) |
                    (SLAVE_MODE_SELECT == MODE_10BIT_START_STOP);
  wire ten_bit = SLAVE_MODE_SELECT[MODE_TEN_BIT_POS];
  wire ss_irq = mode_valid & SLAVE_MODE_SELECT[MODE_START_STOP_POS];
  wire sw_ack = ADDRESS_HOLD_ENABLE | DATA_HOLD_ENABLE;

  // ----------------------------------------------------------------
  // address compare
  // ----------------------------------------------------------------
  wire rw_bit = shift_q[RW_BIT_POS];
  wire match7 = (shift_q[7:1] == addr_q[7:1]);
  wire high_hit = (shift_q[7:3] == TEN_BIT_PREFIX) &
                  (shift_q[2:1] == addr_q[HIGH_A9_POS:HIGH_A8_POS]);
  wire high_write = high_hit & ~rw_bit;
  wire high_read = high_hit & rw_bit & full_match10_q;
  wire low_hit = (shift_q == addr_q);
  wire in_addr = (state_q == ST_ADDR);
  wire in_low = (state_q == ST_LOW);
  wire in_data = (state_q == ST_DATA);
  wire accept_addr = ten_bit ? (high_write | high_read) : match7;
  wire want_ack = (in_addr & accept_addr) | (in_low & low_hit) | in_data;
  wire busy = full_q | ov_q;
  wire ack_ok = want_ack & ~busy;

  // ----------------------------------------------------------------
  // flag set and clear terms
  // ----------------------------------------------------------------
  wire load_buf = byte_done & ack_ok;
  wire ov_set = byte_done & want_ack & busy;
  wire irq_byte = byte_done & (ack_ok | in_low);
  wire irq_cond = ss_irq & (start_det | stop_det);
  wire irq_set = irq_byte | irq_cond;
  wire upd_set = ack_end & upd_pending_q;
  wire ack_time_set = byte_done & want_ack & sw_ack;
  wire ack_release = hold_ack_q & ACK_GO;
  wire high_ack = in_addr & ten_bit & high_write & ack_ok;

  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (!mode_valid || stop_det) begin
      state_d = ST_IDLE;
    end else if (start_det) begin
      state_d = ST_ADDR;
    end else if (byte_done) begin
      case (state_q)
        ST_ADDR: begin
          if (!ack_ok) begin
            state_d = ST_IDLE;
          end else if (ten_bit) begin
            state_d = high_read ? ST_READ : ST_LOW;
          end else begin
            state_d = rw_bit ? ST_READ : ST_DATA;
          end
        end
        ST_LOW: begin
          state_d = ack_ok ? ST_DATA : ST_IDLE;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  assign bit_cnt_d = (start_det | ack_end) ? BIT_COUNT_RESET :
                     (rise_evt_q & (bit_cnt_q != ACK_END_COUNT)) ? bit_cnt_q + 4'h1 :
                     bit_cnt_q;
  assign ack_phase_d = (start_det | ack_end) ? 1'b0 :
                       byte_done ? 1'b1 :
                       ack_phase_q;
  assign full_match10_d = (stop_det | ~mode_valid) ? 1'b0 :
                          (byte_done & in_low) ? low_hit :
                          full_match10_q;
  assign upd_pending_d = (start_det | stop_det | ack_end) ? 1'b0 :
                         (byte_done & (high_ack | in_low)) ? 1'b1 :
                         upd_pending_q;
  assign hold_upd_d = upd_set | (hold_upd_q & ~ADDRESS_WRITE);
  assign hold_ack_d = ack_time_set | (hold_ack_q & ~ACK_GO & ~start_det & ~stop_det);
  assign sda_oe_d = (start_det | stop_det | ack_end) ? 1'b0 :
                    byte_done ? (ack_ok & ~sw_ack) :
                    ack_release ? (ack_ok_q & ~ACK_DATA) :
                    sda_oe_q;

  // ----------------------------------------------------------------
  // bus sampling registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      toggle_prev_q <= 1'b0;
      rise_evt_q <= 1'b0;
    end else begin
      scl_prev_q <= lines.scl;
      sda_prev_q <= lines.sda;
      toggle_prev_q <= lines.rise_toggle;
      rise_evt_q <= rise_now;
    end
  end

  // bit taken one cycle after its toggle so both have settled
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      shift_q <= BUFFER_RESET;
      bit_cnt_q <= BIT_COUNT_RESET;
      ack_phase_q <= 1'b0;
    end else begin
      if (rise_evt_q && !ack_phase_q) begin
        shift_q <= {shift_q[6:0], lines.rise_bit};
      end
      bit_cnt_q <= bit_cnt_d;
      ack_phase_q <= ack_phase_d;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      full_match10_q <= 1'b0;
      upd_pending_q <= 1'b0;
      ack_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      full_match10_q <= full_match10_d;
      upd_pending_q <= upd_pending_d;
      if (byte_done) begin
        ack_ok_q <= ack_ok;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      addr_q <= ADDRESS_RESET;
    end else if (ADDRESS_WRITE) begin
      addr_q <= ADDRESS_WRITE_DATA;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      buffer_q <= BUFFER_RESET;
    end else if (load_buf) begin
      buffer_q <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // sticky flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      full_q <= 1'b0;
      ov_q <= 1'b0;
      irq_q <= 1'b0;
      upd_q <= 1'b0;
      ack_time_q <= 1'b0;
    end else begin
      full_q <= load_buf | (full_q & ~BUFFER_READ);
      ov_q <= ov_set | (ov_q & ~OVERFLOW_CLEAR);
      irq_q <= irq_set | (irq_q & ~IRQ_CLEAR);
      upd_q <= upd_set | (upd_q & ~ADDRESS_WRITE);
      ack_time_q <= ack_time_set | (ack_time_q & ~ack_end);
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      hold_upd_q <= 1'b0;
      hold_ack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      drive_level_q <= 1'b0;
    end else begin
      hold_upd_q <= hold_upd_d;
      hold_ack_q <= hold_ack_d;
      scl_oe_q <= hold_upd_d | hold_ack_d;
      sda_oe_q <= sda_oe_d;
      drive_level_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      addressed_q <= 1'b0;
      read_q <= 1'b0;
    end else begin
      addressed_q <= (state_d == ST_DATA) | (state_d == ST_READ);
      read_q <= (state_d == ST_READ);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SCL_OUT = drive_level_q;
  assign SCL_OE = scl_oe_q;
  assign SDA_OUT = drive_level_q;
  assign SDA_OE = sda_oe_q;
  assign SLAVE_ADDRESS_REG = addr_q;
  assign RECEIVE_BUFFER_REG = buffer_q;
  assign BUFFER_FULL_FLAG = full_q;
  assign RECEIVE_OVERFLOW_FLAG = ov_q;
  assign SERIAL_PORT_IRQ_FLAG = irq_q;
  assign ADDRESS_UPDATE_NEEDED = upd_q;
  assign ACK_TIME_FLAG = ack_time_q;
  assign ADDRESSED = addressed_q;
  assign READ_REQUEST = read_q;

endmodule

`default_nettype wire

// ==== i2c_addr_pkg.sv ====
// constants, types and the line carrier for the two-wire slave address front end
// assumes a 250 MHz system clock and a separate clock taken from the bus clock wire
package i2c_addr_pkg;

  // ----------------------------------------------------------------
  // slave mode select encodings
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_7BIT = 4'h6;
  localparam logic [3:0] MODE_10BIT = 4'h7;
  localparam logic [3:0] MODE_7BIT_START_STOP = 4'hE;
  localparam logic [3:0] MODE_10BIT_START_STOP = 4'hF;
  localparam int MODE_TEN_BIT_POS = 0;
  localparam int MODE_START_STOP_POS = 3;

  // ----------------------------------------------------------------
  // address layout
  // ----------------------------------------------------------------
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam int HIGH_A9_POS = 2;
  localparam int HIGH_A8_POS = 1;
  localparam int RW_BIT_POS = 0;

  // ----------------------------------------------------------------
  // bit counting and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
  localparam logic [3:0] ACK_BIT_COUNT = 4'h8;
  localparam logic [3:0] ACK_END_COUNT = 4'h9;
  localparam logic [7:0] ADDRESS_RESET = 8'h00;
  localparam logic [7:0] BUFFER_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_LOW,
    ST_DATA,
    ST_READ
  } state_type;

  typedef struct packed {
    logic scl;
    logic sda;
    logic rise_toggle;
    logic rise_bit;
  } lines_type;

  localparam lines_type LINES_RESET = 4'hC;

endpackage

// ==== bit_sync.sv ====
// two flip-flop level synchroniser, one per bit of a vector
// assumes every bit is a level that stays put far longer than two clock periods
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= RESET_VALUE;
      stage2_q <= RESET_VALUE;
    end else begin
      stage1_q <= d;
      stage2_q <= stage1_q;
    end
  end

  assign q = stage2_q;

endmodule

`default_nettype wire

// ==== scl_edge_sampler.sv ====
// bus clock domain: samples the data wire on each rising bus clock edge
// assumes the bus clock stands still outside frames; reset forces constants
`timescale 1ns/100ps
`default_nettype none

module scl_edge_sampler (
  // bus clock and reset
  input wire logic scl_clk,
  input wire logic rst,
  // data wire
  input wire logic sda,
  // sample and its event toggle
  output logic toggle,
  output logic bit_value
);

  logic toggle_q;
  logic bit_q;

  // toggle flags a new sample; the bit holds until the next rising edge
  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      toggle_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      toggle_q <= ~toggle_q;
      bit_q <= sda;
    end
  end

  assign toggle = toggle_q;
  assign bit_value = bit_q;

endmodule

`default_nettype wire

// ==== i2c_slave_address_match_checker.sv ====
// concurrent checks on the ports of the address front end
// assumes one system clock domain and binding to the top module
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_address_match_checker
  import i2c_addr_pkg::*;
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // watched ports
  input wire logic SCL_OE,
  input wire logic SDA_OE,
  input wire logic [3:0] SLAVE_MODE_SELECT,
  input wire logic ADDRESS_HOLD_ENABLE,
  input wire logic DATA_HOLD_ENABLE,
  input wire logic ADDRESS_WRITE,
  input wire logic [7:0] ADDRESS_WRITE_DATA,
  input wire logic [7:0] SLAVE_ADDRESS_REG,
  input wire logic BUFFER_FULL_FLAG,
  input wire logic RECEIVE_OVERFLOW_FLAG,
  input wire logic SERIAL_PORT_IRQ_FLAG,
  input wire logic ADDRESS_UPDATE_NEEDED,
  input wire logic ACK_TIME_FLAG,
  input wire logic ADDRESSED,
  input wire logic READ_REQUEST
);
  // ----
  // helpers and sequences
  // ----
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  wire logic no_hold = !ADDRESS_HOLD_ENABLE && !DATA_HOLD_ENABLE;
  wire logic mode_ok = SLAVE_MODE_SELECT inside {MODE_7BIT, MODE_10BIT,
    MODE_7BIT_START_STOP, MODE_10BIT_START_STOP};
  sequence stretch_s;
    ##[0:2] SCL_OE;
  endsequence
  sequence ack_s;
    ##[0:2] SDA_OE;
  endsequence
  // ----
  // assertions
  // ----
  addr_load_a: assert property (ADDRESS_WRITE |=>
    SLAVE_ADDRESS_REG == $past(ADDRESS_WRITE_DATA)) else $error("address not loaded");
  upd_clear_a: assert property (ADDRESS_WRITE && ADDRESS_UPDATE_NEEDED |=>
    !ADDRESS_UPDATE_NEEDED) else $error("update flag not cleared");
  upd_stretch_a: assert property ($rose(ADDRESS_UPDATE_NEEDED) |-> stretch_s)
    else $error("no stretch with update flag");
  upd_release_a: assert property (ADDRESS_WRITE && ADDRESS_UPDATE_NEEDED &&
    !ACK_TIME_FLAG |-> ##[1:2] !SCL_OE) else $error("stretch not released");
  match_irq_a: assert property ($rose(BUFFER_FULL_FLAG) |-> SERIAL_PORT_IRQ_FLAG)
    else $error("buffer loaded without irq");
  hw_ack_a: assert property ($rose(BUFFER_FULL_FLAG) && no_hold |-> ack_s)
    else $error("no hardware ack");
  ovf_nack_a: assert property ($rose(RECEIVE_OVERFLOW_FLAG) |-> !SDA_OE [*8])
    else $error("ack on overflow");
  ack_time_a: assert property ($rose(ACK_TIME_FLAG) |-> !no_hold ##0 stretch_s)
    else $error("ack time flag wrong");
  mode_off_a: assert property (!mode_ok |=> !ADDRESSED && !READ_REQUEST)
    else $error("addressed in invalid mode");
  read_addr_a: assert property ($rose(READ_REQUEST) |-> ADDRESSED)
    else $error("read request while idle");
endmodule
bind i2c_slave_address_match i2c_slave_address_match_checker i_chk (.*);
`default_nettype wire

// ==== i2c_master_model.sv ====
// behavioural two-wire bus master that pulls the wires low or releases them
// assumes the bench resolves both wires with pull-ups
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
  // resolved wires
  input wire logic scl,
  input wire logic sda,
  // pull-down requests
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // release the clock, wait out a stretching slave, hold high
  task automatic clk_high();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (!scl && n < 4000) begin
      n++;
      #1;
    end
    #40;
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low = !b;
    #20;
    clk_high();
    s = sda;
    scl_low = 1'b1;
    #20;
  endtask
  // start or repeated start
  task automatic start();
    #1.3;
    sda_low = 1'b0;
    #20;
    clk_high();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #20;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #20;
    clk_high();
    sda_low = 1'b0;
    #40;
  endtask
  // msb first, then the ack bit; ack_n low means acknowledged
  task automatic send_byte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack_n);
  endtask
endmodule
`default_nettype wire

// ==== i2c_slave_address_match_tb_top.sv ====
// self-checking bench: address front end facing a bus master model
// assumes package, master model and checker are compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module i2c_slave_address_match_tb_top import i2c_addr_pkg::*;;
  logic clock = 1'b0, reset = 1'b1, addr_hold = 1'b0, data_hold = 1'b0, aw = 1'b0;
  logic ack_go = 1'b0, ack_dt = 1'b0, buf_rd = 1'b0, irq_clr = 1'b0, ovf_clr = 1'b0, ack_n;
  logic [3:0] mode = 4'h0;
  logic [7:0] aw_data = 8'h00, r;
  logic [6:0] a7;
  logic [9:0] a10;
  wire logic scl, sda, scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low;
  wire logic rx_full, ovf, irq, upd_need, ack_tim, addressed, rd_req;
  wire logic [7:0] addr_reg, rx_buf;
  int num_errors = 0, cmp_count = 0, cycles = 0, n, seed = 32'h4EC047F0;
  // ----
  // clock, wires, instances
  // ----
  always #2 clock = ~clock;
  assign scl = !m_scl_low && !(scl_oe && !scl_out);
  assign sda = !m_sda_low && !(sda_oe && !sda_out);
  i2c_slave_address_match i_i2c_slave_address_match (.CLOCK(clock), .RESET(reset),
    .SCL_CLK(scl), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SLAVE_MODE_SELECT(mode),
    .ADDRESS_HOLD_ENABLE(addr_hold), .DATA_HOLD_ENABLE(data_hold), .ADDRESS_WRITE(aw),
    .ADDRESS_WRITE_DATA(aw_data), .SLAVE_ADDRESS_REG(addr_reg), .ACK_GO(ack_go),
    .ACK_DATA(ack_dt), .BUFFER_READ(buf_rd), .IRQ_CLEAR(irq_clr), .OVERFLOW_CLEAR(ovf_clr),
    .RECEIVE_BUFFER_REG(rx_buf), .BUFFER_FULL_FLAG(rx_full), .RECEIVE_OVERFLOW_FLAG(ovf),
    .SERIAL_PORT_IRQ_FLAG(irq), .ADDRESS_UPDATE_NEEDED(upd_need), .ACK_TIME_FLAG(ack_tim),
    .ADDRESSED(addressed), .READ_REQUEST(rd_req));
  i2c_master_model i_i2c_master_model (.scl(scl), .sda(sda), .scl_low(m_scl_low),
    .sda_low(m_sda_low));
  // ----
  // tasks and expectations
  // ----
  task automatic test_done();
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wr_addr(input logic [7:0] d);
    @(negedge clock);
    aw = 1'b1;
    aw_data = d;
    tick(1);
    aw = 1'b0;
  endtask
  task automatic clr_flags();
    @(negedge clock);
    {buf_rd, irq_clr, ovf_clr} = 3'b111;
    tick(1);
    {buf_rd, irq_clr, ovf_clr} = 3'b000;
  endtask
  task automatic xfer(input logic [7:0] d);
    i_i2c_master_model.send_byte(d, ack_n);
    tick(10);
  endtask
  function automatic logic [7:0] hi_byte(input logic [9:0] a, input logic rw);
    return {TEN_BIT_PREFIX, a[9:8], rw};
  endfunction
  // ----
  // scenarios
  // ----
  initial begin
    tick(3);
    reset = 1'b0;
    tick(3);
    for (int m = 0; m < 3; m++) begin
      mode = m[0] ? MODE_7BIT_START_STOP : MODE_7BIT;
      a7 = 7'($random(seed));
      wr_addr({a7, 1'b0});
      clr_flags();
      i_i2c_master_model.start();
      tick(10);
      `CHK("start irq", mode[MODE_START_STOP_POS], irq)
      clr_flags();
      xfer({a7 ^ {m[1], 6'h00}, m[0]});
      `CHK("addr ack", m[1], ack_n)
      `CHK("addr irq", !m[1], irq)
      `CHK("rx full", !m[1], rx_full)
      if (m == 0) begin
        `CHK("rx buffer", {a7, 1'b0}, rx_buf)
        xfer(8'($random(seed)));
        `CHK("overflow nack", 1'b1, ack_n)
        `CHK("overflow", 1'b1, ovf)
      end
      clr_flags();
      i_i2c_master_model.stop();
      tick(10);
      `CHK("stop irq", mode[MODE_START_STOP_POS], irq)
    end
    for (int m = 0; m < 2; m++) begin
      mode = m[0] ? MODE_10BIT_START_STOP : MODE_10BIT;
      a10 = 10'($random(seed));
      r = 8'($random(seed));
      wr_addr({r[7:3], a10[9:8], r[0]});
      i_i2c_master_model.start();
      xfer(hi_byte(a10, 1'b1));
      `CHK("early read ack", 1'b1, ack_n)
      `CHK("early read", 1'b0, rd_req)
      i_i2c_master_model.start();
      xfer(hi_byte(a10, 1'b0));
      `CHK("high ack", 1'b0, ack_n)
      `CHK("high stretch", 2'b11, {upd_need, scl_oe})
      wr_addr(a10[7:0]);
      tick(2);
      `CHK("update clear", 1'b0, upd_need)
      `CHK("address reg", a10[7:0], addr_reg)
      clr_flags();
      xfer(a10[7:0] ^ {!m[0], 7'h00});
      `CHK("low ack", !m[0], ack_n)
      `CHK("low flags", 3'b111, {irq, upd_need, scl_oe})
      wr_addr({r[7:3], a10[9:8], r[0]});
      if (m == 1) begin
        // software empties the buffer, else the read address is refused
        clr_flags();
        i_i2c_master_model.start();
        xfer(hi_byte(a10, 1'b1));
        `CHK("read ack", 1'b0, ack_n)
        `CHK("read request", 1'b1, rd_req)
      end
      i_i2c_master_model.stop();
      tick(10);
    end
    mode = MODE_7BIT;
    a7 = 7'($random(seed));
    wr_addr({a7, 1'b0});
    clr_flags();
    r = 8'($random(seed));
    addr_hold = r[0];
    data_hold = !r[0];
    i_i2c_master_model.start();
    fork
      i_i2c_master_model.send_byte({a7, 1'b0}, ack_n);
      begin
        n = 0;
        while (!ack_tim && n < 2000) begin
          tick(1);
          n++;
        end
        tick(4);
        `CHK("ack time", 2'b11, {ack_tim, scl_oe})
        ack_dt = r[1];
        ack_go = 1'b1;
        tick(1);
        ack_go = 1'b0;
      end
    join
    tick(10);
    `CHK("software ack", r[1], ack_n)
    mode = 4'h0;
    tick(4);
    `CHK("mode off", 1'b0, addressed)
    i_i2c_master_model.stop();
    test_done();
  end
endmodule
`default_nettype wire
